/* File: verilog/hpd_pkg.sv */
// Constants, field layouts and carrier types of the headphone driver block
package hpd_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned MS_PER_SEC = 1000;
   localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_SEC;
   localparam int unsigned DLY_MAX_MS = 4000;

   // ---------------------------------------------------------------
   // Control port
   // ---------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR = 7'h18;
   localparam int unsigned NUM_DRV = 4;

   // ---------------------------------------------------------------
   // Register offsets (active page 0, except page select, which every page reaches)
   // ---------------------------------------------------------------
   localparam logic [7:0] PAGE_SEL_OFS = 8'h00;
   localparam logic [7:0] HEADSET_TYPE_DETECT_OFS = 8'h0D;
   localparam logic [7:0] OUTPUT_CONFIG_TYPE_OFS = 8'h0E;
   localparam logic [7:0] SHORT_PROTECT_CONTROL_OFS = 8'h26;
   localparam logic [7:0] SOFT_STEP_CONTROL_OFS = 8'h28;
   localparam logic [7:0] POWERUP_DELAY_AND_IDLE_STATE_OFS = 8'h2A;
   localparam logic [7:0] DRIVER_SHORT_STATUS_OFS = 8'h5F;
   localparam logic [7:0] JACK_DETECT_CONFIG_A_OFS = 8'h60;
   localparam logic [7:0] JACK_DETECT_CONFIG_B_OFS = 8'h61;
   localparam logic [7:0] DRIVER_CONTROL_BASE_OFS = 8'h33;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned CFG_TYPE_LSB = 6;
   localparam int unsigned HS_TYPE_LSB = 4;
   localparam int unsigned SC_DETECT_BIT = 2;
   localparam int unsigned SC_AUTO_OFF_BIT = 1;
   localparam int unsigned SS_DISABLE_BIT = 1;
   localparam int unsigned PD_DELAY_LSB = 4;
   localparam int unsigned PD_IDLE_LSB = 2;
   localparam int unsigned DC_LEVEL_LSB = 4;
   localparam int unsigned DC_DIRECT_BIT = 1;
   localparam int unsigned DC_POWER_BIT = 0;
   localparam int unsigned JB_JACK_BIT = 0;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] PAGE_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] CFG_DIFF = 2'h0;
   localparam logic [1:0] CFG_SE4 = 2'h1;
   localparam logic [1:0] CFG_SE_VCM1 = 2'h2;
   localparam logic [1:0] CFG_SE_VCM2 = 2'h3;
   localparam logic [1:0] HS_MONO = 2'h1;
   localparam logic [1:0] HS_STEREO = 2'h2;
   localparam logic [3:0] LEVEL_MAX_DB = 4'h9;
   localparam logic [4:0] ATTEN_MAX = 5'h1F;

   typedef struct packed {
      logic on;
      logic [1:0] idle;
      logic vcm_hold;
      logic direct;
      logic [4:0] atten;
      logic [3:0] level;
   } hpd_drv_t;

   // Power-up delay in ms for each code
   function automatic logic [11:0] hpd_dly_ms(input logic [2:0] code);
      case (code)
         3'h0: hpd_dly_ms = 12'h000;
         3'h1: hpd_dly_ms = 12'h00A;
         3'h2: hpd_dly_ms = 12'h032;
         3'h3: hpd_dly_ms = 12'h064;
         3'h4: hpd_dly_ms = 12'h0C8;
         3'h5: hpd_dly_ms = 12'h190;
         3'h6: hpd_dly_ms = 12'h3E8;
         default: hpd_dly_ms = 12'(DLY_MAX_MS);
      endcase
   endfunction

endpackage

/* File: verilog/hpd_driver_ctl.sv */
// Power sequencing, soft-step and short latch of one output driver
`timescale 1ns/1ps
`default_nettype none
module hpd_driver_ctl
   import hpd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic pwr_req,
   input wire logic auto_off,
   input wire logic soft_en,
   input wire logic [2:0] dly_code,
   input wire logic ms_tick,
   // Analog status
   input wire logic short_in,
   // State
   output logic on_ff,
   output logic [4:0] atten_ff,
   output logic flag_ff
);

   typedef enum {HPD_OFF, HPD_WAIT, HPD_STEP, HPD_ON, HPD_SHUT} hpd_st_t;

   hpd_st_t st_ff, nxt_st;
   logic [11:0] cnt_ff, nxt_cnt;
   logic [4:0] nxt_atten;
   logic nxt_flag;

   wire live = (st_ff == HPD_WAIT) || (st_ff == HPD_STEP) || (st_ff == HPD_ON);
   wire trip = live && auto_off && short_in;

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_atten = atten_ff;
      nxt_flag = flag_ff;
      case (st_ff)
         HPD_OFF: begin
            nxt_atten = soft_en ? ATTEN_MAX : 5'h00; // R5
            if (pwr_req) begin
               nxt_flag = 1'b0; // R9
               nxt_cnt = hpd_dly_ms(dly_code); // R3
               nxt_st = HPD_WAIT;
            end
         end
         HPD_WAIT: begin
            if (cnt_ff == 12'h000) begin
               nxt_st = soft_en ? HPD_STEP : HPD_ON; // R5
            end else if (ms_tick) begin
               nxt_cnt = cnt_ff - 12'h001; // R3
            end
         end
         HPD_STEP: begin
            if (atten_ff == 5'h00) begin
               nxt_st = HPD_ON;
            end else if (ms_tick) begin
               nxt_atten = atten_ff - 5'h01; // R5
            end
         end
         HPD_ON: nxt_st = HPD_ON;
         HPD_SHUT: nxt_st = HPD_SHUT;
         default: nxt_st = HPD_OFF;
      endcase
      if (trip) begin
         nxt_st = HPD_SHUT; // R9
         nxt_flag = 1'b1; // R9
      end else if (!pwr_req) begin
         nxt_st = HPD_OFF;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= HPD_OFF;
         cnt_ff <= 12'h000;
         atten_ff <= ATTEN_MAX;
         flag_ff <= 1'b0;
         on_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         atten_ff <= nxt_atten;
         flag_ff <= nxt_flag;
         on_ff <= (nxt_st == HPD_STEP) || (nxt_st == HPD_ON);
      end
   end

endmodule // hpd_driver_ctl
`default_nettype wire

/* File: verilog/hpd_top.sv */
// Headphone driver power, protection and jack detect with I2C registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - The four drivers run as two differential, four single-ended, or two single-ended outputs with one or two drivers holding common mode.
// R2 - Software sets the output configuration type before powering the drivers.
// R3 - A driver waits a delay from zero to 4 s, chosen in the delay register, after its power-up request.
// R4 - A powered-down driver sits in the idle state chosen in the delay register: off, weak common mode or weak half supply.
// R5 - With soft-stepping on, the default, a driver starts fully attenuated and steps down to its programmed gain.
// R6 - Each driver has a level setting adding at most 9 dB for full-scale trimming.
// R7 - The two main drivers offer a direct converter route that bypasses volume and mixing.
// R8 - A shorted driver limits its current and the short condition is readable in the short status register.
// R9 - With automatic shutdown on, a short powers the driver down and latches a flag that only power-down then power-up clears.
// R10 - Jack detection is set up through its configuration registers and the headset type reads back in the detect register.
// R11 - With AC-coupled outputs the mono or stereo distinction is not reported.
// R12 - Differential headphone detection relies on short detection with automatic shutdown enabled by the host.
// R13 - Register addresses resolve within the page chosen by writing register zero, page zero after reset.
// R14 - Each driver keeps its own power state, delay timer and short flag.
module hpd_top
   import hpd_pkg::*;
#(
   parameter int unsigned MS_CYC = MS_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control port
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out_ff,
   output logic sda_oe_ff,
   // Analog status
   input wire logic [3:0] short_in,
   input wire logic [1:0] headset_type_in,
   input wire logic jack_in,
   // Driver controls
   output hpd_drv_t [3:0] drv_ff
);

   // ---------------------------------------------------------------
   // Control port slave
   // ---------------------------------------------------------------
   typedef enum {I2_IDLE, I2_ADDR, I2_ACKA, I2_REG, I2_WDAT, I2_ACKW,
                 I2_RDAT, I2_RACK} hpd_i2_t;

   hpd_i2_t i2_ff;
   logic scl_q_ff, sda_q_ff, rw_ff, ptr_set_ff;
   logic [3:0] bit_ff;
   logic [7:0] sr_ff, tx_ff, ptr_ff, rd_ff;

   wire scl_rise = scl && !scl_q_ff;
   wire scl_fall = !scl && scl_q_ff;
   wire i2_start = scl && scl_q_ff && sda_q_ff && !sda_in;
   wire i2_stop = scl && scl_q_ff && !sda_q_ff && sda_in;
   wire byte_done = scl_fall && (bit_ff == 4'h8);
   wire addr_hit = (sr_ff[7:1] == DEV_ADDR);
   // Pointer byte only moves the pointer, data bytes write
   wire wr_stb = scl_fall && (i2_ff == I2_ACKW) && !ptr_set_ff;
   // Ninth clock of a byte is the acknowledge, not data
   wire shift_en = scl_rise && (bit_ff < 4'h8);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         i2_ff <= I2_IDLE;
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         rw_ff <= 1'b0;
         ptr_set_ff <= 1'b0;
         bit_ff <= 4'h0;
         sr_ff <= 8'h00;
         tx_ff <= 8'h00;
         ptr_ff <= 8'h00;
         sda_oe_ff <= 1'b0;
      end else begin
         scl_q_ff <= scl;
         sda_q_ff <= sda_in;
         if (shift_en) begin
            sr_ff <= {sr_ff[6:0], sda_in};
            bit_ff <= bit_ff + 4'h1;
         end
         if (i2_start) begin
            i2_ff <= I2_ADDR;
            bit_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
         end else if (i2_stop) begin
            i2_ff <= I2_IDLE;
            sda_oe_ff <= 1'b0;
         end else begin
            case (i2_ff)
               I2_ADDR: if (byte_done) begin
                  sda_oe_ff <= addr_hit;
                  rw_ff <= sr_ff[0];
                  i2_ff <= addr_hit ? I2_ACKA : I2_IDLE;
               end
               I2_ACKA: if (scl_fall) begin
                  bit_ff <= 4'h0;
                  tx_ff <= rd_ff;
                  sda_oe_ff <= rw_ff && !rd_ff[7];
                  i2_ff <= rw_ff ? I2_RDAT : I2_REG;
               end
               I2_REG, I2_WDAT: if (byte_done) begin
                  sda_oe_ff <= 1'b1;
                  i2_ff <= I2_ACKW;
                  ptr_set_ff <= (i2_ff == I2_REG);
               end
               I2_ACKW: if (scl_fall) begin
                  bit_ff <= 4'h0;
                  sda_oe_ff <= 1'b0;
                  ptr_ff <= ptr_set_ff ? sr_ff : ptr_ff + 8'h01;
                  i2_ff <= I2_WDAT;
               end
               I2_RDAT: if (scl_fall) begin
                  if (bit_ff == 4'h8) begin
                     sda_oe_ff <= 1'b0;
                     ptr_ff <= ptr_ff + 8'h01;
                     i2_ff <= I2_RACK;
                  end else begin
                     tx_ff <= {tx_ff[6:0], 1'b0};
                     sda_oe_ff <= !tx_ff[6];
                  end
               end
               I2_RACK: begin
                  if (scl_rise && sda_in) begin
                     i2_ff <= I2_IDLE;
                  end else if (scl_fall) begin
                     bit_ff <= 4'h0;
                     tx_ff <= rd_ff;
                     sda_oe_ff <= !rd_ff[7];
                     i2_ff <= I2_RDAT;
                  end
               end
               I2_IDLE: sda_oe_ff <= 1'b0;
               default: i2_ff <= I2_IDLE;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [7:0] page_ff, hs_ff, cfg_ff, sc_ff, ss_ff, pd_ff, ja_ff, jb_ff;
   logic [7:0] dc_ff [4];
   logic [3:0] flag;
   logic [3:0] on;
   logic [4:0] atten [4];

   wire pg0 = (page_ff == 8'h00); // R13
   wire wr_page = wr_stb && (ptr_ff == PAGE_SEL_OFS); // R13
   wire wr_p0 = wr_stb && pg0;
   wire [1:0] cfg_type = cfg_ff[CFG_TYPE_LSB +: 2];
   wire ac_coupled = (cfg_type == CFG_SE4);
   wire [1:0] hs_type = (ac_coupled && headset_type_in == HS_MONO) ?
                        HS_STEREO : headset_type_in; // R11
   wire [7:0] dc_idx = ptr_ff - DRIVER_CONTROL_BASE_OFS;
   wire dc_hit = pg0 && (ptr_ff >= DRIVER_CONTROL_BASE_OFS) &&
                 (dc_idx < 8'(NUM_DRV));
   wire auto_off = sc_ff[SC_DETECT_BIT] && sc_ff[SC_AUTO_OFF_BIT]; // R12
   wire soft_en = !ss_ff[SS_DISABLE_BIT]; // R5
   wire [2:0] dly_code = pd_ff[PD_DELAY_LSB +: 3]; // R3
   wire [7:0] stat = {short_in, flag}; // R8

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         page_ff <= PAGE_RESET; // R13
         hs_ff <= REG_RESET;
         cfg_ff <= REG_RESET;
         sc_ff <= REG_RESET;
         ss_ff <= REG_RESET;
         pd_ff <= REG_RESET;
         ja_ff <= REG_RESET;
         jb_ff <= REG_RESET;
         for (int i = 0; i < 4; i++) begin
            dc_ff[i] <= REG_RESET;
         end
      end else begin
         if (wr_page) page_ff <= {7'h00, sr_ff[0]};
         if (wr_p0) begin
            case (ptr_ff)
               HEADSET_TYPE_DETECT_OFS: hs_ff <= sr_ff; // R10
               OUTPUT_CONFIG_TYPE_OFS: cfg_ff <= sr_ff; // R2
               SHORT_PROTECT_CONTROL_OFS: sc_ff <= sr_ff;
               SOFT_STEP_CONTROL_OFS: ss_ff <= sr_ff;
               POWERUP_DELAY_AND_IDLE_STATE_OFS: pd_ff <= sr_ff;
               JACK_DETECT_CONFIG_A_OFS: ja_ff <= sr_ff; // R10
               JACK_DETECT_CONFIG_B_OFS: jb_ff <= sr_ff; // R10
               default: ;
            endcase
            if (dc_hit) dc_ff[dc_idx[1:0]] <= sr_ff;
         end
      end
   end

   // Read data registered from the pointer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_ff <= 8'h00;
      end else if (ptr_ff == PAGE_SEL_OFS) begin
         rd_ff <= page_ff;
      end else if (!pg0) begin
         rd_ff <= 8'h00;
      end else if (dc_hit) begin
         rd_ff <= dc_ff[dc_idx[1:0]];
      end else begin
         case (ptr_ff)
            HEADSET_TYPE_DETECT_OFS:
               rd_ff <= {hs_ff[7:6], hs_type, hs_ff[3:0]}; // R10
            OUTPUT_CONFIG_TYPE_OFS: rd_ff <= cfg_ff;
            SHORT_PROTECT_CONTROL_OFS: rd_ff <= sc_ff;
            SOFT_STEP_CONTROL_OFS: rd_ff <= ss_ff;
            POWERUP_DELAY_AND_IDLE_STATE_OFS: rd_ff <= pd_ff;
            DRIVER_SHORT_STATUS_OFS: rd_ff <= stat; // R8
            JACK_DETECT_CONFIG_A_OFS: rd_ff <= ja_ff;
            JACK_DETECT_CONFIG_B_OFS: rd_ff <= {jb_ff[7:1], jack_in};
            default: rd_ff <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Millisecond tick and per-driver sequencers
   // ---------------------------------------------------------------
   logic [31:0] ms_cnt_ff;
   logic ms_tick_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ms_cnt_ff <= 32'h0000_0000;
         ms_tick_ff <= 1'b0;
      end else begin
         ms_tick_ff <= (ms_cnt_ff == 32'(MS_CYC - 1));
         ms_cnt_ff <= (ms_cnt_ff == 32'(MS_CYC - 1)) ? 32'h0000_0000 :
                      ms_cnt_ff + 32'h0000_0001;
      end
   end

   for (genvar g = 0; g < 4; g++) begin : g_drv
      hpd_driver_ctl u_ctl ( // R14
         .clk(clk),
         .rst(rst),
         .pwr_req(dc_ff[g][DC_POWER_BIT]),
         .auto_off(auto_off), // R9
         .soft_en(soft_en),
         .dly_code(dly_code),
         .ms_tick(ms_tick_ff),
         .short_in(short_in[g]),
         .on_ff(on[g]),
         .atten_ff(atten[g]),
         .flag_ff(flag[g])
      );
   end

   // Pin-facing driver state
   function automatic logic vcm_for(input int unsigned idx,
                                    input logic [1:0] ct);
      vcm_for = (ct == CFG_SE_VCM2 && idx >= 2) ||
                (ct == CFG_SE_VCM1 && idx == 2); // R1
   endfunction

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drv_ff <= '0;
         sda_out_ff <= 1'b0;
      end else begin
         sda_out_ff <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            drv_ff[i].on <= on[i];
            drv_ff[i].idle <= pd_ff[PD_IDLE_LSB +: 2]; // R4
            drv_ff[i].vcm_hold <= vcm_for(i, cfg_type); // R1
            drv_ff[i].direct <= (i < 2) && dc_ff[i][DC_DIRECT_BIT]; // R7
            drv_ff[i].atten <= atten[i];
            drv_ff[i].level <=
               (dc_ff[i][DC_LEVEL_LSB +: 4] > LEVEL_MAX_DB) ?
               LEVEL_MAX_DB : dc_ff[i][DC_LEVEL_LSB +: 4]; // R6
         end
      end
   end

endmodule // hpd_top
`default_nettype wire

/* File: sim/hpd_chk_properties.sv */
// Port assertions for the headphone driver block
`timescale 1ns/1ps
`default_nettype none
module hpd_chk
   import hpd_pkg::*;
#(
   parameter int unsigned MS_CYC = MS_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control port
   input wire logic scl,
   input wire logic sda_out_ff,
   input wire logic sda_oe_ff,
   // Driver state
   input wire hpd_drv_t [3:0] drv_ff
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_level_max;
      drv_ff[0].level <= LEVEL_MAX_DB && drv_ff[1].level <= LEVEL_MAX_DB &&
      drv_ff[2].level <= LEVEL_MAX_DB && drv_ff[3].level <= LEVEL_MAX_DB;
   endproperty
   a_level_max: assert property (p_level_max)
      else $error("level above limit");
   property p_direct_main;
      !drv_ff[2].direct && !drv_ff[3].direct;
   endproperty
   a_direct_main: assert property (p_direct_main)
      else $error("direct route on common driver");
   property p_vcm_side;
      !drv_ff[0].vcm_hold && !drv_ff[1].vcm_hold &&
      (!drv_ff[3].vcm_hold || drv_ff[2].vcm_hold);
   endproperty
   a_vcm_side: assert property (p_vcm_side)
      else $error("common mode hold on wrong driver");
   property p_idle_shared;
      drv_ff[0].idle == drv_ff[1].idle && drv_ff[1].idle == drv_ff[2].idle &&
      drv_ff[2].idle == drv_ff[3].idle;
   endproperty
   a_idle_shared: assert property (p_idle_shared)
      else $error("idle state differs");
   property p_soft_step;
      drv_ff[0].on && $past(drv_ff[0].on) |->
         5'($past(drv_ff[0].atten) - drv_ff[0].atten) <= 5'h01;
   endproperty
   a_soft_step: assert property (p_soft_step)
      else $error("attenuation jump");
   property p_ack_scl_low;
      $rose(sda_oe_ff) |-> !scl && !$past(scl);
   endproperty
   a_ack_scl_low: assert property (p_ack_scl_low)
      else $error("data drive starts with clock high");
   property p_sda_stands;
      scl && $past(scl) |-> $stable(sda_oe_ff);
   endproperty
   a_sda_stands: assert property (p_sda_stands)
      else $error("data changed with clock high");
   property p_open_drain;
      sda_out_ff == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("data line driven high");
endmodule // hpd_chk
bind hpd_top hpd_chk #(.MS_CYC(MS_CYC)) u_hpd_chk (.clk(clk), .rst(rst),
   .scl(scl), .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff),
   .drv_ff(drv_ff));
`default_nettype wire

/* File: sim/hpd_jack_model.sv */
// Jack and load model facing the driver outputs
`timescale 1ns/1ps
`default_nettype none
module hpd_jack_model
   import hpd_pkg::*;
(
   // Scenario control
   input wire logic plugged,
   input wire logic [1:0] hs_code,
   // Toward the block
   output logic [3:0] short_in,
   output logic [1:0] headset_type_in,
   output logic jack_in
);
   // Spring contact grounds left main output on removal
   assign short_in = {3'h0, !plugged};
   assign headset_type_in = plugged ? hs_code : 2'h0;
   assign jack_in = plugged;
endmodule // hpd_jack_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the headphone driver block
`timescale 1ns/1ps
`default_nettype none
module tb
   import hpd_pkg::*;
;
   localparam int unsigned MSC = 10;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic scl = 1'b1;
   logic sda_low = 1'b0;
   logic plugged = 1'b1;
   logic [1:0] hs_code = HS_STEREO;
   logic sda_out_ff;
   logic sda_oe_ff;
   logic jack_in;
   logic [3:0] short_in;
   logic [1:0] headset_type_in;
   hpd_drv_t [3:0] drv_ff;
   wire logic sda = !(sda_low || sda_oe_ff);
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;
   logic ack;
   logic [7:0] ofs [5] = '{OUTPUT_CONFIG_TYPE_OFS, SHORT_PROTECT_CONTROL_OFS,
      SOFT_STEP_CONTROL_OFS, POWERUP_DELAY_AND_IDLE_STATE_OFS,
      JACK_DETECT_CONFIG_A_OFS};

   always #10 clk = !clk;

   hpd_top #(.MS_CYC(MSC)) u_hpd_top (.clk(clk), .rst(rst), .scl(scl),
      .sda_in(sda), .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff),
      .short_in(short_in), .headset_type_in(headset_type_in),
      .jack_in(jack_in), .drv_ff(drv_ff));
   hpd_jack_model u_hpd_jack_model (.plugged(plugged), .hs_code(hs_code),
      .short_in(short_in), .headset_type_in(headset_type_in),
      .jack_in(jack_in));

   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      tick(4);
      scl = 1'b1;
      tick(3);
      r = sda;
      tick(3);
      scl = 1'b0;
      tick(1);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic a);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      a = !r;
   endtask
   task automatic rbyte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, r);
   endtask
   task automatic start_c;
      sda_low = 1'b0;
      tick(5);
      scl = 1'b1;
      tick(4);
      sda_low = 1'b1;
      tick(4);
      scl = 1'b0;
      tick(1);
   endtask
   task automatic stop_c;
      sda_low = 1'b1;
      tick(5);
      scl = 1'b1;
      tick(4);
      sda_low = 1'b0;
      tick(5);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic k1, k2, k3;
      start_c;
      wbyte({DEV_ADDR, 1'b0}, k1);
      wbyte(a, k2);
      wbyte(d, k3);
      stop_c;
      chk("write_ack", 8'h07, {5'h00, k1, k2, k3});
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
      input logic [7:0] e);
      logic k;
      logic [7:0] d;
      start_c;
      wbyte({DEV_ADDR, 1'b0}, k);
      wbyte(a, k);
      start_c;
      wbyte({DEV_ADDR, 1'b1}, k);
      rbyte(d);
      stop_c;
      chk(nm, e, d);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         give_verdict;
      end
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      tick(2);
      rchk("page_rst", PAGE_SEL_OFS, PAGE_RESET);
      for (int i = 0; i < 5; i++) rchk("reg_rst", ofs[i], REG_RESET);
      for (int i = 0; i < 5; i++) begin
         wr(ofs[i], 8'h5A);
         rchk("reg_rw", ofs[i], 8'h5A);
      end
      wr(PAGE_SEL_OFS, 8'h01);
      rchk("page_sel", PAGE_SEL_OFS, 8'h01);
      rchk("page1_rd", OUTPUT_CONFIG_TYPE_OFS, 8'h00);
      wr(OUTPUT_CONFIG_TYPE_OFS, 8'h77);
      wr(PAGE_SEL_OFS, 8'h00);
      rchk("page0_rd", OUTPUT_CONFIG_TYPE_OFS, 8'h5A);
      rchk("unmapped", 8'h10, 8'h00);
      start_c;
      wbyte(8'h32, ack);
      stop_c;
      chk("wrong_addr", 8'h00, {7'h00, ack});
      wr(HEADSET_TYPE_DETECT_OFS, 8'hFF);
      wr(OUTPUT_CONFIG_TYPE_OFS, 8'h40);
      hs_code = HS_MONO;
      rchk("ac_type", HEADSET_TYPE_DETECT_OFS, {2'h3, HS_STEREO, 4'hF});
      for (int c = 0; c < 4; c++) begin
         wr(OUTPUT_CONFIG_TYPE_OFS, 8'(c << 6));
         chk("vcm", {6'h00, c == 3, c >= 2},
            {6'h00, drv_ff[3].vcm_hold, drv_ff[2].vcm_hold});
      end
      wr(OUTPUT_CONFIG_TYPE_OFS, 8'h00);
      rchk("hs_type", HEADSET_TYPE_DETECT_OFS, {2'h3, HS_MONO, 4'hF});
      rchk("jack_in", JACK_DETECT_CONFIG_B_OFS, 8'h01);
      wr(SOFT_STEP_CONTROL_OFS, 8'h00);
      wr(POWERUP_DELAY_AND_IDLE_STATE_OFS, 8'h18);
      wr(DRIVER_CONTROL_BASE_OFS, 8'hF1);
      tick(50);
      chk("early_on", 8'h00, {7'h00, drv_ff[0].on});
      for (n = 0; n < 200 && drv_ff[0].on !== 1'b1; n++) tick(1);
      chk("delay", 8'h01, {7'h00, n > 20 && n < 70});
      chk("atten_hi", 8'h01, {7'h00, drv_ff[0].atten >= 5'h1E});
      tick(33 * MSC);
      chk("atten_lo", 8'h00, {3'h0, drv_ff[0].atten});
      chk("level", 8'h09, {4'h0, drv_ff[0].level});
      chk("idle", 8'h02, {6'h00, drv_ff[1].idle});
      chk("iso_off", 8'h00, {7'h00, drv_ff[1].on});
      wr(DRIVER_CONTROL_BASE_OFS + 8'h01, 8'h03);
      wr(DRIVER_CONTROL_BASE_OFS + 8'h02, 8'h02);
      chk("direct", 8'h01, {6'h00, drv_ff[2].direct, drv_ff[1].direct});
      wr(SHORT_PROTECT_CONTROL_OFS, 8'h04);
      plugged = 1'b0;
      rchk("limit", DRIVER_SHORT_STATUS_OFS, 8'h10);
      rchk("jack_out", JACK_DETECT_CONFIG_B_OFS, 8'h00);
      chk("stay_on", 8'h01, {7'h00, drv_ff[0].on});
      plugged = 1'b1;
      wr(SHORT_PROTECT_CONTROL_OFS, 8'h06);
      plugged = 1'b0;
      tick(5);
      chk("trip", 8'h00, {7'h00, drv_ff[0].on});
      plugged = 1'b1;
      rchk("latched", DRIVER_SHORT_STATUS_OFS, 8'h01);
      chk("iso_on", 8'h01, {7'h00, drv_ff[1].on});
      wr(DRIVER_CONTROL_BASE_OFS, 8'h00);
      wr(DRIVER_CONTROL_BASE_OFS, 8'h01);
      rchk("cleared", DRIVER_SHORT_STATUS_OFS, 8'h00);
      chk("repower", 8'h01, {7'h00, drv_ff[0].on});
      give_verdict;
   end
endmodule // tb
`default_nettype wire
